// File: fwsp_flash_model.sv
`timescale 1ns/1ps
module fwsp_flash_model (
  input  wire logic        load,
  input  wire logic        erase,
  input  wire logic        stuck,
  input  wire logic [7:0]  reads,
  input  wire logic [15:0] word,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  output logic [15:0]      dq,
  output logic             ready_busy_n
);
  int          done_n = 0;
  int          base   = 0;
  logic        kill   = 1'b1;
  logic        tog    = 1'b0;
  logic        busy;
  logic [15:0] st;
  // protected targets are just short busy windows
  assign busy = !kill && (stuck || done_n < base);
  // toggle flips per read only while busy
  always @(posedge oe_n) begin
    done_n = done_n + 1;
    if (busy) tog = ~tog;
  end
  // busy from command end, reset command returns to read
  always @(posedge load or posedge we_n) begin
    kill = !load;
    base = done_n + int'(reads);
  end
  // status word, array data when idle
  assign st = busy ? {word[15:8], erase ? 1'b0 : ~word[7], tog, stuck, word[4:3],
                      erase ? tog : word[2], word[1:0]} : word;
  assign dq = (ce_n || oe_n) ? ~st : st;
  assign ready_busy_n = !busy;
endmodule : fwsp_flash_model

// File: fwsp_host.sv
`timescale 1ns/1ps
`include "fwsp_regs.svh"
// How it works
// R1: poll bit 7 equals programmed bit when done, inverted while busy.
// R2: protected program address: status about 1 us, then array data.
// R3: erase poll bit 7 reads 0 busy, 1 done or suspended.
// R4: all erase sectors protected: status about 100 us then read mode.
// R5: partly protected erase: status in protected sector may be invalid.
// R6: host polls at program address, or inside a sector being erased.
// R7: chip erase: host polls any non-protected sector address.
// R8: status valid only after last write strobe of a command.
// R9: bit 7 may flip first; host confirms with a further read.
// R10: host rereads bit 7 after seeing the limit flag set.
// R11: ready/busy pin low while programming or erasing.
// R12: bit 6 inverts each read while busy, stops when done.
// R13: bit 6 valid right after command, also in erase timeout.
// R14: bit 6 stops in erase suspend, resumes for suspend program.
// R15: bit 6 toggles 100 us or 1 us for protected targets.
// R16: bit 2 inverts on reads inside sectors selected for erase.
// R17: host reads twice and compares the toggle bit; stable means done.
// R18: toggling with limit flag: recheck, still toggling means fail, reset.
// R19: host restarts toggle polling from two fresh reads after leaving.
// R20: bit 5 set when operation passes its pulse limit.
// R21: bit 3 reads 0 during erase timeout, 1 once erase starts.
// R22: bit 1 set on buffer write abort until abort reset.
// R23: idle device returns array contents on all data bits.
module fwsp_host
  import fwsp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hsel,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic [21:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  input  wire logic        ready_busy_n
);
  fwsp_s_t s_q;
  fwsp_s_t s_d;
  logic    tb_changed;
  logic    tb_changed2;

  assign hreadyout    = s_q.hready;
  assign hrdata       = s_q.hrdata;
  assign hresp        = 1'b0;
  assign flash_addr   = s_q.pins.addr;
  assign flash_dq_out = s_q.pins.dout;
  assign flash_dq_oe  = s_q.pins.dq_oe;
  assign flash_ce_n   = s_q.pins.ce_n;
  assign flash_oe_n   = s_q.pins.oe_n;
  assign flash_we_n   = s_q.pins.we_n;

  // R17 toggle compare of two reads
  assign tb_changed  = (s_q.first[`FWSP_BIT_TOGGLE] != s_q.dq_s2[`FWSP_BIT_TOGGLE]);
  assign tb_changed2 = (s_q.last[`FWSP_BIT_TOGGLE] != s_q.dq_s2[`FWSP_BIT_TOGGLE]);

  always_comb begin
    s_d = s_q;
    s_d.dq_s1 = {16'h0000, flash_dq_in};
    s_d.dq_s2 = s_q.dq_s1[15:0];
    s_d.ryby_s = {s_q.ryby_s[0], ready_busy_n};
    s_d.hready = 1'b1;
    // ahb data phase of a write
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      if (s_q.hofs == `FWSP_OFS_CTRL) begin
        s_d.start    = hwdata[`FWSP_CTRL_START];
        s_d.mode_tog = hwdata[`FWSP_CTRL_TOGGLE];
        s_d.abort    = hwdata[`FWSP_CTRL_ABORT];
      end else if (s_q.hofs == `FWSP_OFS_ADDR) begin
        s_d.tgt = hwdata[21:0];
      end else if (s_q.hofs == `FWSP_OFS_DATA) begin
        s_d.expect_d = hwdata[15:0];
      end
    end
    if (s_q.rd_pend) begin
      s_d.rd_pend = 1'b0;
    end
    // ahb address phase
    if (hsel && hready && htrans[1]) begin
      s_d.hofs = haddr[7:0];
      s_d.wr_pend = hwrite;
      s_d.rd_pend = !hwrite;
      s_d.hrdata = 32'h00000000;
      if (haddr[7:0] == `FWSP_OFS_CTRL) begin
        s_d.hrdata = {29'h0, s_q.abort, s_q.mode_tog, s_q.start};
      end else if (haddr[7:0] == `FWSP_OFS_ADDR) begin
        s_d.hrdata = {10'h000, s_q.tgt};
      end else if (haddr[7:0] == `FWSP_OFS_DATA) begin
        s_d.hrdata = {16'h0000, s_q.expect_d};
      end else if (haddr[7:0] == `FWSP_OFS_STATUS) begin
        // R11 ready/busy pin reported
        s_d.hrdata = {28'h0, s_q.ryby_s[1], s_q.fail, s_q.done, s_q.busy | s_q.start};
      end else if (haddr[7:0] == `FWSP_OFS_RDATA) begin
        s_d.hrdata = {16'h0000, s_q.last};
      end
    end
    // flash read and reset command write cycle sequencer
    case (s_q.st)
      FWSP_IDLE: begin
        s_d.pins.ce_n  = 1'b1;
        s_d.pins.oe_n  = 1'b1;
        s_d.pins.we_n  = 1'b1;
        s_d.pins.dq_oe = 1'b0;
        if (s_q.start) begin
          // R6 R7 poll at the target address
          s_d.pins.addr = s_q.tgt;
          if (!(s_q.wr_pend && s_q.hofs == `FWSP_OFS_CTRL)) begin
            s_d.start = 1'b0;
          end
          s_d.busy  = 1'b1;
          s_d.done  = 1'b0;
          s_d.fail  = 1'b0;
          s_d.cnt   = 8'h00;
          s_d.phase = 2'b00;
          // R19 always restart from two fresh reads
          s_d.st    = FWSP_RD1;
        end
      end
      FWSP_RD1, FWSP_RD2, FWSP_RD3: begin
        s_d.pins.ce_n = 1'b0;
        s_d.pins.oe_n = 1'b0;
        s_d.cnt = s_q.cnt + 8'h01;
        if (s_q.cnt == `FWSP_RD_CYC) begin
          s_d.cnt = 8'h00;
          s_d.pins.ce_n = 1'b1;
          s_d.pins.oe_n = 1'b1;
          s_d.last = s_q.dq_s2;
          if (s_q.abort) begin
            if (!(s_q.wr_pend && s_q.hofs == `FWSP_OFS_CTRL)) begin
              s_d.abort = 1'b0;
            end
            s_d.st = FWSP_RST;
          end else if (s_q.st == FWSP_RD1) begin
            s_d.first = s_q.dq_s2;
            s_d.st = FWSP_RD2;
          end else if (s_q.mode_tog) begin
            if (s_q.st == FWSP_RD2 && !tb_changed) begin
              // R17 stable toggle bit means done
              s_d.st = FWSP_DONE;
            end else if (s_q.st == FWSP_RD3 && !tb_changed2) begin
              s_d.st = FWSP_DONE;
            end else if (s_q.st == FWSP_RD3) begin
              // R18 still toggling after limit flag
              s_d.fail = 1'b1;
              s_d.st = FWSP_RST;
            end else if (s_q.dq_s2[`FWSP_BIT_LIMIT]) begin
              s_d.st = FWSP_RD3;
            end else begin
              s_d.first = s_q.dq_s2;
            end
          end else begin
            // R1 bit 7 matches expected data
            if (s_q.dq_s2[`FWSP_BIT_POLL] == s_q.expect_d[`FWSP_BIT_POLL]) begin
              // R9 confirm with a further full read
              s_d.st = (s_q.st == FWSP_RD3) ? FWSP_DONE : FWSP_RD3;
            end else if (s_q.st == FWSP_RD3) begin
              // R10 reread after limit flag, still wrong
              s_d.fail = 1'b1;
              s_d.st = FWSP_RST;
            end else if (s_q.dq_s2[`FWSP_BIT_LIMIT]) begin
              s_d.st = FWSP_RD3;
            end
          end
        end
      end
      FWSP_RST: begin
        // R18 reset command write
        s_d.pins.dout  = `FWSP_RESET_CMD;
        s_d.pins.dq_oe = 1'b1;
        s_d.pins.ce_n  = 1'b0;
        s_d.pins.we_n  = 1'b0;
        s_d.cnt = s_q.cnt + 8'h01;
        if (s_q.cnt == `FWSP_RD_CYC) begin
          s_d.pins.we_n = 1'b1;
          s_d.pins.ce_n = 1'b1;
          s_d.cnt = 8'h00;
          s_d.st  = FWSP_DONE;
        end
      end
      FWSP_DONE: begin
        s_d.pins.dq_oe = 1'b0;
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.st   = FWSP_IDLE;
      end
      default: s_d.st = FWSP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.st <= FWSP_IDLE;
      s_q.hready <= 1'b1;
      s_q.pins.ce_n <= 1'b1;
      s_q.pins.oe_n <= 1'b1;
      s_q.pins.we_n <= 1'b1;
      s_q.ryby_s <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : fwsp_host

// File: fwsp_host_properties.sv
`timescale 1ns/1ps
module fwsp_host_properties (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        flash_dq_oe,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  chk_read_length: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*4])
    else $error("read pulse too short");
  chk_read_addr: assert property (!flash_oe_n && $past(!flash_oe_n) |-> $stable(flash_addr))
    else $error("address moved in read");
  chk_read_ce: assert property (!flash_oe_n |-> !flash_ce_n)
    else $error("read without chip enable");
  chk_no_contend: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("host drives data in read");
  chk_reset_word: assert property (!flash_we_n |-> flash_dq_oe && flash_dq_out == 16'h00f0)
    else $error("bad reset command word");
  chk_reset_len: assert property ($fell(flash_we_n) |-> !flash_we_n [*4])
    else $error("write pulse too short");
  chk_strobe_excl: assert property (flash_we_n || flash_oe_n)
    else $error("read and write strobes overlap");
  chk_bus_ready: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
endmodule : fwsp_host_properties
bind fwsp_host fwsp_host_properties chk (.clk_sys(clk_sys), .nrst(nrst), .hreadyout(hreadyout),
  .hresp(hresp), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out));

// File: fwsp_host_tb.sv
`timescale 1ns/1ps
`include "fwsp_regs.svh"
module fwsp_host_tb
  import fwsp_pkg::*;
;
  typedef struct packed {logic [31:0] v; logic [31:0] m;} fwsp_chk_t;
  logic        clk_sys, nrst, hwrite, hsel, hreadyout, hresp, mon_rd, load, erase, stuck;
  logic        flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, ready_busy_n;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] flash_dq_out, flash_dq_in, dq_m, word;
  logic [21:0] flash_addr, tgt;
  logic [7:0]  reads;
  logic [2:0]  hsize;
  logic [1:0]  htrans;
  int          errors = 0, total_checks = 0, seed = 46575, cyc = 0, resets = 0;
  fwsp_chk_t   q[$];
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : dq_m;
  fwsp_host dut (.clk_sys(clk_sys), .nrst(nrst), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .ready_busy_n(ready_busy_n));
  fwsp_flash_model mdl (.load(load), .erase(erase), .stuck(stuck), .reads(reads),
    .word(word), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .dq(dq_m),
    .ready_busy_n(ready_busy_n));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic complete_run;
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      complete_run();
    end
    if ($fell(flash_oe_n)) check("flash_addr", {10'h0, flash_addr}, {10'h0, tgt});
    if ($fell(flash_we_n)) resets++;
    if (mon_rd && hreadyout) check("hrdata", hrdata & q[0].m, q[0].v);
    if (mon_rd && hreadyout) void'(q.pop_front());
  end
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic m, output logic [31:0] r);
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsel   <= 1'b1;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    mon_rd <= m;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
    mon_rd <= 1'b0;
  endtask : ahb
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    logic [31:0] r;
    q.push_back('{v, m});
    ahb(1'b0, a, 32'h0, 1'b1, r);
  endtask : expect_rd
  task automatic run(input logic t, input logic e, input logic s, input logic ab,
                     input logic [7:0] n);
    logic [31:0] r;
    logic [15:0] w;
    w = 16'($random(seed)) | {8'h0, e, 7'h0};
    tgt = 22'($random(seed));
    word <= w;
    erase <= e;
    stuck <= s;
    reads <= n;
    ahb(1'b1, `FWSP_OFS_ADDR, {10'h0, tgt}, 1'b0, r);
    load <= 1'b1;
    ahb(1'b1, `FWSP_OFS_DATA, {16'h0, w}, 1'b0, r);
    load <= 1'b0;
    ahb(1'b1, `FWSP_OFS_CTRL, {29'h0, 1'b0, t, 1'b1}, 1'b0, r);
    if (ab) ahb(1'b1, `FWSP_OFS_CTRL, 32'h4, 1'b0, r);
    r = 32'h1;
    for (int k = 0; k < 400 && r[0] !== 1'b0; k++) ahb(1'b0, `FWSP_OFS_STATUS, 0, 1'b0, r);
  endtask : run
  initial begin
    {nrst, haddr, htrans, hwrite, hwdata, hsel, mon_rd, load, erase, stuck} = '0;
    {reads, word, tgt} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    expect_rd(`FWSP_OFS_STATUS, 32'h8, 32'hf);
    expect_rd(8'h14, 32'h0, 32'hffffffff);
    for (int i = 0; i < 8; i++) begin
      run(i[0], i[1], 1'b0, 1'b0, {5'h0, 3'($random(seed))});
      expect_rd(`FWSP_OFS_STATUS, 32'h2, 32'h7);
      expect_rd(`FWSP_OFS_RDATA, {16'h0, word}, 32'hffff);
    end
    for (int i = 0; i < 3; i++) begin
      int r0;
      r0 = resets;
      run(i[0], 1'b0, i < 2, i == 2, 8'hfa);
      expect_rd(`FWSP_OFS_STATUS, {29'h1, i < 2, 2'h0}, 32'hd);
      check("resets", resets, r0 + 1);
    end
    complete_run();
  end
endmodule : fwsp_host_tb

// File: fwsp_pkg.sv
package fwsp_pkg;
  typedef enum logic [5:0] {
    FWSP_IDLE  = 6'h01,
    FWSP_RD1   = 6'h02,
    FWSP_RD2   = 6'h04,
    FWSP_RD3   = 6'h08,
    FWSP_RST   = 6'h10,
    FWSP_DONE  = 6'h20
  } fwsp_state_t;

  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] dout;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } fwsp_pins_t;

  typedef struct packed {
    fwsp_state_t st;
    logic [7:0]  cnt;
    logic [1:0]  phase;
    logic [15:0] first;
    logic [15:0] last;
    logic        mode_tog;
    logic        busy;
    logic        done;
    logic        fail;
    logic        start;
    logic        abort;
    logic [21:0] tgt;
    logic [15:0] expect_d;
    logic        hready;
    logic [31:0] hrdata;
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  hofs;
    fwsp_pins_t  pins;
    logic [1:0]  ryby_s;
    logic [31:0] dq_s1;
    logic [15:0] dq_s2;
  } fwsp_s_t;
endpackage : fwsp_pkg

// File: fwsp_regs.svh
`ifndef FWSP_REGS_SVH
`define FWSP_REGS_SVH
`define FWSP_OFS_CTRL    8'h00
`define FWSP_OFS_ADDR    8'h04
`define FWSP_OFS_DATA    8'h08
`define FWSP_OFS_STATUS  8'h0c
`define FWSP_OFS_RDATA   8'h10
`define FWSP_CTRL_START  0
`define FWSP_CTRL_TOGGLE 1
`define FWSP_CTRL_ABORT  2
`define FWSP_ST_BUSY     0
`define FWSP_ST_DONE     1
`define FWSP_ST_FAIL     2
`define FWSP_ST_RYBY     3
`define FWSP_BIT_POLL    7
`define FWSP_BIT_TOGGLE  6
`define FWSP_BIT_LIMIT   5
`define FWSP_BIT_SECTOG  2
`define FWSP_RD_CYC      8'h04
`define FWSP_RESET_CMD   16'h00f0
`endif
